// ==== verilog/dram_pkg.sv ====
// Timing, geometry and state encoding for the memory module controller
package dram_pkg;
    localparam int ROW_W       = 11;
    localparam int COL_W       = 11;
    localparam int ADDR_W      = ROW_W + COL_W;
    localparam int PIN_ADDR_W  = 11;
    localparam int DATA_W      = 9;
    localparam int REF_ROW_W   = 10;
    localparam int CNT_W       = 4;
    localparam int WAKE_W      = 4;
    localparam logic [WAKE_W-1:0] INIT_RAS_CYCLES = 4'h8;
    localparam logic [REF_ROW_W-1:0] REF_ROW_RST  = 10'h000;

    // Clock period and device times in ns, power-up pause in us, idle limit in ms
    localparam int CLK_NS                             = 10;
    localparam int row_to_column_strobe_delay_NS      = 20;
    localparam int row_address_hold_interval_NS       = 10;
    localparam int row_referenced_access_time_NS      = 60;
    localparam int column_referenced_access_time_NS   = 20;
    localparam int row_strobe_min_low_time_NS         = 60;
    localparam int column_strobe_min_low_time_NS      = 20;
    localparam int row_precharge_interval_NS          = 40;
    localparam int write_to_row_lead_interval_NS      = 20;
    localparam int write_to_column_lead_interval_NS   = 20;
    localparam int column_precharge_interval_NS       = 10;
    localparam int page_mode_row_max_low_time_NS      = 200000;
    localparam int PWRUP_PAUSE_US                     = 200;
    localparam int IDLE_LIMIT_MS                      = 16;
    localparam int REFRESH_INTERVAL_NS                = 15600;

    // Least times round up, the idle limit rounds down
    localparam int RCD_CYC = (row_to_column_strobe_delay_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int RAH_CYC = (row_address_hold_interval_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int RAS_CYC = (row_strobe_min_low_time_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int CAS_CYC = (column_strobe_min_low_time_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int CAC_CYC = (column_referenced_access_time_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int RAC_CYC = (row_referenced_access_time_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int CWL_CYC = (write_to_column_lead_interval_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int RWL_CYC = (write_to_row_lead_interval_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int RP_CYC  = (row_precharge_interval_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int CP_CYC  = (column_precharge_interval_NS + CLK_NS - 1)
                             / CLK_NS;
    localparam int PWRUP_CYC_DEF = (PWRUP_PAUSE_US * 1000 + CLK_NS - 1)
                                   / CLK_NS;
    localparam int IDLE_CYC_DEF  = (IDLE_LIMIT_MS * 1000000) / CLK_NS;
    // Longest times round down
    localparam int RASP_CYC_DEF  = page_mode_row_max_low_time_NS / CLK_NS;
    localparam int REFI_CYC      = REFRESH_INTERVAL_NS / CLK_NS;

    // Column strobe low time covers every lower bound
    localparam int COL_A   = (CAS_CYC > CAC_CYC) ? CAS_CYC : CAC_CYC;
    localparam int COL_B   = (CWL_CYC > RWL_CYC) ? CWL_CYC : RWL_CYC;
    localparam int COL_C   = (RAS_CYC > RAC_CYC) ? RAS_CYC - RCD_CYC
                                                 : RAC_CYC - RCD_CYC;
    localparam int COL_AB  = (COL_A > COL_B) ? COL_A : COL_B;
    localparam int COL_CYC = (COL_AB > COL_C) ? COL_AB : COL_C;
    // Worst case cycles of one more page access
    localparam int PAGE_CYC = CP_CYC + 1 + COL_CYC;

    typedef enum logic [9:0] {
        ST_PWRUP = 10'h001,
        ST_IDLE  = 10'h002,
        ST_ROW   = 10'h004,
        ST_COL   = 10'h008,
        ST_CPRE  = 10'h010,
        ST_PAGE  = 10'h020,
        ST_RPRE  = 10'h040,
        ST_ROR   = 10'h080,
        ST_HPRE  = 10'h100,
        ST_HACT  = 10'h200
    } state_t;
endpackage

// ==== verilog/dram_tmr_if.sv ====
// Carrier between the controller and its time base
`timescale 1ns/1ps
interface dram_tmr_if;
    logic refresh_tick;
    logic idle_stale;
    logic pwrup_done;
    logic row_activity;
    logic refresh_en;

    modport timer (
        output refresh_tick,
        output idle_stale,
        output pwrup_done,
        input  row_activity,
        input  refresh_en
    );
    modport ctrl (
        input  refresh_tick,
        input  idle_stale,
        input  pwrup_done,
        output row_activity,
        output refresh_en
    );
endinterface

// ==== verilog/dram_timebase.sv ====
// Power-up pause, refresh interval and idle watch counters
`timescale 1ns/1ps
module dram_timebase #(
    parameter int PWRUP_CYC = dram_pkg::PWRUP_CYC_DEF,
    parameter int IDLE_CYC  = dram_pkg::IDLE_CYC_DEF
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    dram_tmr_if.timer  tm
);
    logic [31:0] pwr_cnt_ff;
    logic [31:0] nxt_pwr_cnt;
    logic [31:0] refi_cnt_ff;
    logic [31:0] nxt_refi_cnt;
    logic [31:0] idle_cnt_ff;
    logic [31:0] nxt_idle_cnt;
    logic        pwr_done_ff;
    logic        nxt_pwr_done;
    logic        tick_ff;
    logic        nxt_tick;
    logic        stale_ff;
    logic        nxt_stale;

    always_comb begin
        nxt_pwr_cnt  = pwr_cnt_ff;
        nxt_pwr_done = pwr_done_ff;
        nxt_refi_cnt = refi_cnt_ff;
        nxt_tick     = 1'b0;
        nxt_idle_cnt = idle_cnt_ff;
        nxt_stale    = stale_ff;
        // Power-up pause
        if (!pwr_done_ff) begin
            if (pwr_cnt_ff >= 32'(PWRUP_CYC - 1)) begin
                nxt_pwr_done = 1'b1;
            end else begin
                nxt_pwr_cnt = pwr_cnt_ff + 32'h1;
            end
        end
        // One row refresh per interval
        if (pwr_done_ff && tm.refresh_en) begin
            if (refi_cnt_ff >= 32'(dram_pkg::REFI_CYC - 1)) begin
                nxt_refi_cnt = 32'h0;
                nxt_tick     = 1'b1;
            end else begin
                nxt_refi_cnt = refi_cnt_ff + 32'h1;
            end
        end
        // Idle watch, restarted by any row strobe activity
        if (tm.row_activity || !pwr_done_ff) begin
            nxt_idle_cnt = 32'h0;
            nxt_stale    = 1'b0;
        end else if (idle_cnt_ff >= 32'(IDLE_CYC - 1)) begin
            nxt_stale = 1'b1;
        end else begin
            nxt_idle_cnt = idle_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_cnt_ff  <= 32'h0;
            pwr_done_ff <= 1'b0;
            refi_cnt_ff <= 32'h0;
            tick_ff     <= 1'b0;
            idle_cnt_ff <= 32'h0;
            stale_ff    <= 1'b0;
        end else begin
            pwr_cnt_ff  <= nxt_pwr_cnt;
            pwr_done_ff <= nxt_pwr_done;
            refi_cnt_ff <= nxt_refi_cnt;
            tick_ff     <= nxt_tick;
            idle_cnt_ff <= nxt_idle_cnt;
            stale_ff    <= nxt_stale;
        end
    end

    assign tm.pwrup_done   = pwr_done_ff;
    assign tm.refresh_tick = tick_ff;
    assign tm.idle_stale   = stale_ff;
endmodule

// ==== verilog/dram_ctrl.sv ====
// Strobe-sequencing controller for a multiplexed-address memory module
`timescale 1ns/1ps
// Operation
// [RQ1] Wait 200 us, then eight row cycles
// [RQ2] After 16 ms idle, eight wake-up cycles
// [RQ3] Eleven row then eleven column bits
// [RQ4] Row strobe first, column after minimum delay
// [RQ5] Column strobe ignored until row hold met
// [RQ6] Write enable high before column fall reads
// [RQ7] Column fall inside maximum delay for access
// [RQ8] Strobes held minimum, write enable high after
// [RQ9] Row strobe high for precharge interval
// [RQ10] Read data only while column strobe low
// [RQ11] Write enable low before column fall writes
// [RQ12] Write data referenced to column fall
// [RQ13] Strobes low long enough after write
// [RQ14] Row stays open across column accesses
// [RQ15] Column precharge between page accesses
// [RQ16] Mixed page accesses within row maximum
// [RQ17] Row rises with or after column
// [RQ18] One row refresh every 15.6 us
// [RQ19] Every access refreshes its row
// [RQ20] Top line, write enable ignored in refresh
// [RQ21] Row-only refresh walks external counter
// [RQ22] Column-first refresh uses internal counter
// [RQ23] Write enable high around column-first refresh
// [RQ24] Hidden refresh keeps column strobe low
module dram_ctrl #(
    parameter int PWRUP_CYC = dram_pkg::PWRUP_CYC_DEF,
    parameter int IDLE_CYC  = dram_pkg::IDLE_CYC_DEF,
    parameter int RASP_CYC  = dram_pkg::RASP_CYC_DEF
) (
    input  wire logic                          CLK_I,
    input  wire logic                          SYS_RST_I,
    input  wire logic                          REFRESH_EN_I,
    input  wire logic                          REQ_VALID_I,
    input  wire logic                          REQ_WRITE_I,
    input  wire logic [dram_pkg::ADDR_W-1:0]   REQ_ADDR_I,
    input  wire logic [dram_pkg::DATA_W-1:0]   REQ_WDATA_I,
    output wire logic                          REQ_READY_O,
    output wire logic                          RD_VALID_O,
    output wire logic [dram_pkg::DATA_W-1:0]   RD_DATA_O,
    output wire logic                          INIT_DONE_O,
    output wire logic                          RAS_N_O,
    output wire logic                          CAS_N_O,
    output wire logic                          WE_N_O,
    output wire logic [dram_pkg::PIN_ADDR_W-1:0] ADDR_O,
    output wire logic [dram_pkg::DATA_W-1:0]   DQ_O,
    output wire logic                          DQ_OE_O,
    input  wire logic [dram_pkg::DATA_W-1:0]   DQ_I
);
    function automatic logic [dram_pkg::ROW_W-1:0] row_of(
        input logic [dram_pkg::ADDR_W-1:0] a);
        row_of = a[dram_pkg::ADDR_W-1:dram_pkg::COL_W];
    endfunction

    function automatic logic [dram_pkg::COL_W-1:0] col_of(
        input logic [dram_pkg::ADDR_W-1:0] a);
        col_of = a[dram_pkg::COL_W-1:0];
    endfunction

    dram_tmr_if tm ();

    dram_pkg::state_t                  state_ff;
    dram_pkg::state_t                  nxt_state;
    logic [dram_pkg::CNT_W-1:0]        cnt_ff;
    logic [dram_pkg::CNT_W-1:0]        nxt_cnt;
    logic [31:0]                       ras_cnt_ff;
    logic [31:0]                       nxt_ras_cnt;
    logic                              ras_n_ff;
    logic                              nxt_ras_n;
    logic                              cas_n_ff;
    logic                              nxt_cas_n;
    logic                              we_n_ff;
    logic                              nxt_we_n;
    logic [dram_pkg::PIN_ADDR_W-1:0]   addr_ff;
    logic [dram_pkg::PIN_ADDR_W-1:0]   nxt_addr;
    logic [dram_pkg::DATA_W-1:0]       dq_ff;
    logic [dram_pkg::DATA_W-1:0]       nxt_dq;
    logic                              oe_ff;
    logic                              nxt_oe;
    logic [dram_pkg::ROW_W-1:0]        row_ff;
    logic [dram_pkg::ROW_W-1:0]        nxt_row;
    logic [dram_pkg::COL_W-1:0]        col_ff;
    logic [dram_pkg::COL_W-1:0]        nxt_col;
    logic                              wr_ff;
    logic                              nxt_wr;
    logic [dram_pkg::DATA_W-1:0]       rd_data_ff;
    logic [dram_pkg::DATA_W-1:0]       nxt_rd_data;
    logic                              rd_valid_ff;
    logic                              nxt_rd_valid;
    logic                              ref_due_ff;
    logic                              nxt_ref_due;
    logic [dram_pkg::REF_ROW_W-1:0]    ref_row_ff;
    logic [dram_pkg::REF_ROW_W-1:0]    nxt_ref_row;
    logic                              init_done_ff;
    logic                              nxt_init_done;
    logic [dram_pkg::WAKE_W-1:0]       wake_cnt_ff;
    logic [dram_pkg::WAKE_W-1:0]       nxt_wake_cnt;
    logic                              can_start;
    logic                              can_page;
    logic                              ref_clear;

    dram_timebase #(
        .PWRUP_CYC (PWRUP_CYC),
        .IDLE_CYC  (IDLE_CYC)
    ) u_timebase (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .tm    (tm.timer)
    );

    assign tm.refresh_en = REFRESH_EN_I;

    // Request acceptance
    assign can_start = (state_ff == dram_pkg::ST_IDLE) && init_done_ff
                       && !tm.idle_stale && !ref_due_ff;
    assign can_page  = (state_ff == dram_pkg::ST_CPRE) && (cnt_ff == '0)
                       && !ref_due_ff
                       && (row_of(REQ_ADDR_I) == row_ff)
                       && (ras_cnt_ff < 32'(RASP_CYC - dram_pkg::PAGE_CYC)); // RQ16
    assign REQ_READY_O = can_start || can_page;

    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = (cnt_ff != '0) ? cnt_ff - 4'h1 : cnt_ff;
        nxt_ras_cnt   = ras_n_ff ? 32'h0 : ras_cnt_ff + 32'h1;
        nxt_ras_n     = ras_n_ff;
        nxt_cas_n     = cas_n_ff;
        nxt_we_n      = we_n_ff;
        nxt_addr      = addr_ff;
        nxt_dq        = dq_ff;
        nxt_oe        = oe_ff;
        nxt_row       = row_ff;
        nxt_col       = col_ff;
        nxt_wr        = wr_ff;
        nxt_rd_data   = rd_data_ff;
        nxt_rd_valid  = 1'b0;
        nxt_ref_row   = ref_row_ff;
        nxt_init_done = init_done_ff;
        nxt_wake_cnt  = wake_cnt_ff;
        ref_clear     = 1'b0;
        case (state_ff)
            dram_pkg::ST_PWRUP: begin
                if (tm.pwrup_done) begin // RQ1
                    nxt_state = dram_pkg::ST_IDLE;
                end
            end
            dram_pkg::ST_IDLE: begin
                if (tm.idle_stale && init_done_ff) begin // RQ2
                    nxt_init_done = 1'b0;
                    nxt_wake_cnt  = '0;
                end else if (!init_done_ff || ref_due_ff) begin
                    // Row-only refresh, top line held low
                    nxt_ras_n = 1'b0; // RQ21
                    nxt_addr  = {1'b0, ref_row_ff}; // RQ20
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RAS_CYC - 1);
                    nxt_state = dram_pkg::ST_ROR;
                end else if (REQ_VALID_I) begin
                    nxt_row   = row_of(REQ_ADDR_I);
                    nxt_col   = col_of(REQ_ADDR_I);
                    nxt_wr    = REQ_WRITE_I;
                    nxt_ras_n = 1'b0; // RQ4 RQ19
                    nxt_addr  = row_of(REQ_ADDR_I); // RQ3
                    nxt_we_n  = !REQ_WRITE_I; // RQ6 RQ11
                    nxt_dq    = REQ_WDATA_I;
                    nxt_oe    = REQ_WRITE_I;
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RCD_CYC - 1);
                    nxt_state = dram_pkg::ST_ROW;
                end
            end
            dram_pkg::ST_ROW: begin
                if (cnt_ff <= dram_pkg::CNT_W'(dram_pkg::RCD_CYC
                                               - dram_pkg::RAH_CYC)) begin
                    nxt_addr = col_ff; // RQ5
                end
                if (cnt_ff == '0) begin
                    nxt_cas_n = 1'b0; // RQ4 RQ7 RQ12
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::COL_CYC - 1);
                    nxt_state = dram_pkg::ST_COL;
                end
            end
            dram_pkg::ST_COL: begin
                if (cnt_ff == '0) begin // RQ8 RQ13
                    if (!wr_ff) begin
                        nxt_rd_data  = DQ_I; // RQ10
                        nxt_rd_valid = 1'b1;
                    end
                    nxt_we_n = 1'b1;
                    nxt_oe   = 1'b0;
                    if (ref_due_ff) begin
                        // Column stays low while row precharges
                        nxt_ras_n = 1'b1; // RQ24
                        nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RP_CYC - 1);
                        nxt_state = dram_pkg::ST_HPRE;
                    end else begin
                        nxt_cas_n = 1'b1; // RQ15
                        nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::CP_CYC - 1);
                        nxt_state = dram_pkg::ST_CPRE;
                    end
                end
            end
            dram_pkg::ST_CPRE: begin
                if (cnt_ff == '0) begin
                    if (can_page && REQ_VALID_I) begin // RQ14 RQ16
                        nxt_col   = col_of(REQ_ADDR_I);
                        nxt_wr    = REQ_WRITE_I;
                        nxt_addr  = col_of(REQ_ADDR_I);
                        nxt_we_n  = !REQ_WRITE_I;
                        nxt_dq    = REQ_WDATA_I;
                        nxt_oe    = REQ_WRITE_I;
                        nxt_state = dram_pkg::ST_PAGE;
                    end else begin
                        nxt_ras_n = 1'b1; // RQ17
                        nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RP_CYC - 1);
                        nxt_state = dram_pkg::ST_RPRE;
                    end
                end
            end
            dram_pkg::ST_PAGE: begin
                nxt_cas_n = 1'b0; // RQ15
                nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::COL_CYC - 1);
                nxt_state = dram_pkg::ST_COL;
            end
            dram_pkg::ST_RPRE: begin
                if (cnt_ff == '0) begin // RQ9
                    nxt_state = dram_pkg::ST_IDLE;
                end
            end
            dram_pkg::ST_ROR: begin
                if (cnt_ff == '0) begin
                    nxt_ras_n   = 1'b1;
                    nxt_ref_row = ref_row_ff + 10'h001; // RQ21
                    ref_clear   = 1'b1; // RQ18
                    if (!init_done_ff) begin
                        nxt_wake_cnt = wake_cnt_ff + 4'h1; // RQ1 RQ2
                        if (wake_cnt_ff + 4'h1 >= dram_pkg::INIT_RAS_CYCLES) begin
                            nxt_init_done = 1'b1;
                        end
                    end
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RP_CYC - 1);
                    nxt_state = dram_pkg::ST_RPRE;
                end
            end
            dram_pkg::ST_HPRE: begin
                if (cnt_ff == '0) begin
                    // Column low, write enable high: counter refresh
                    nxt_ras_n = 1'b0; // RQ22 RQ23 RQ24
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RAS_CYC - 1);
                    nxt_state = dram_pkg::ST_HACT;
                end
            end
            dram_pkg::ST_HACT: begin
                if (cnt_ff == '0) begin
                    nxt_ras_n = 1'b1;
                    nxt_cas_n = 1'b1;
                    ref_clear = 1'b1; // RQ18
                    nxt_cnt   = dram_pkg::CNT_W'(dram_pkg::RP_CYC - 1);
                    nxt_state = dram_pkg::ST_RPRE;
                end
            end
            default: begin
                nxt_state = dram_pkg::ST_IDLE;
            end
        endcase
        // New tick wins over a clear in the same cycle
        nxt_ref_due = tm.refresh_tick || (ref_due_ff && !ref_clear); // RQ18
    end

    assign tm.row_activity = ras_n_ff && !nxt_ras_n;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_ff     <= dram_pkg::ST_PWRUP;
            cnt_ff       <= '0;
            ras_cnt_ff   <= 32'h0;
            ras_n_ff     <= 1'b1;
            cas_n_ff     <= 1'b1;
            we_n_ff      <= 1'b1;
            addr_ff      <= '0;
            dq_ff        <= '0;
            oe_ff        <= 1'b0;
            row_ff       <= '0;
            col_ff       <= '0;
            wr_ff        <= 1'b0;
            rd_data_ff   <= '0;
            rd_valid_ff  <= 1'b0;
            ref_due_ff   <= 1'b0;
            ref_row_ff   <= dram_pkg::REF_ROW_RST;
            init_done_ff <= 1'b0;
            wake_cnt_ff  <= '0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            ras_cnt_ff   <= nxt_ras_cnt;
            ras_n_ff     <= nxt_ras_n;
            cas_n_ff     <= nxt_cas_n;
            we_n_ff      <= nxt_we_n;
            addr_ff      <= nxt_addr;
            dq_ff        <= nxt_dq;
            oe_ff        <= nxt_oe;
            row_ff       <= nxt_row;
            col_ff       <= nxt_col;
            wr_ff        <= nxt_wr;
            rd_data_ff   <= nxt_rd_data;
            rd_valid_ff  <= nxt_rd_valid;
            ref_due_ff   <= nxt_ref_due;
            ref_row_ff   <= nxt_ref_row;
            init_done_ff <= nxt_init_done;
            wake_cnt_ff  <= nxt_wake_cnt;
        end
    end

    assign RAS_N_O     = ras_n_ff;
    assign CAS_N_O     = cas_n_ff;
    assign WE_N_O      = we_n_ff;
    assign ADDR_O      = addr_ff;
    assign DQ_O        = dq_ff;
    assign DQ_OE_O     = oe_ff;
    assign RD_DATA_O   = rd_data_ff;
    assign RD_VALID_O  = rd_valid_ff;
    assign INIT_DONE_O = init_done_ff;
endmodule

// ==== test/dram_ctrl_checker.sv ====
// Pin protocol assertions for the memory module controller
`timescale 1ns/1ps
module dram_ctrl_checker (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic RAS_N_O,
    input wire logic CAS_N_O,
    input wire logic WE_N_O,
    input wire logic DQ_OE_O,
    input wire logic REQ_READY_O,
    input wire logic INIT_DONE_O
);
    default clocking dck @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    chk_row_first: assert property (
        $fell(CAS_N_O) |-> !$past(RAS_N_O, 2)) else $error("cas early");
    chk_row_low: assert property (
        $fell(RAS_N_O) |-> !RAS_N_O[*6]) else $error("ras short");
    chk_row_prech: assert property (
        $rose(RAS_N_O) |-> RAS_N_O[*4]) else $error("precharge short");
    chk_col_low: assert property (
        $fell(CAS_N_O) |-> !CAS_N_O[*2]) else $error("cas short");
    chk_page_end: assert property (
        $rose(RAS_N_O) |-> CAS_N_O or
            ((RAS_N_O && !CAS_N_O)[*4] ##1 (!RAS_N_O && !CAS_N_O)))
        else $error("ras before cas");
    chk_read_hold: assert property (
        !CAS_N_O && WE_N_O |=> WE_N_O) else $error("read we drop");
    chk_we_setup: assert property (
        $fell(CAS_N_O) |-> $stable(WE_N_O)) else $error("we setup");
    chk_write_lead: assert property (
        $fell(CAS_N_O) && !WE_N_O |-> (!WE_N_O && !RAS_N_O)[*2])
        else $error("write lead");
    chk_write_data: assert property (
        $fell(CAS_N_O) |-> DQ_OE_O == !WE_N_O) else $error("dq drive");
    chk_refresh_we: assert property (
        $fell(RAS_N_O) && !CAS_N_O |-> WE_N_O && $past(WE_N_O) ##1 WE_N_O)
        else $error("we in refresh");
    chk_init_ready: assert property (
        !INIT_DONE_O |-> !REQ_READY_O) else $error("ready in init");
    cover property ($fell(CAS_N_O) && !$past(RAS_N_O, 4));
    cover property ($fell(RAS_N_O) && !CAS_N_O);
    cover property ($fell(INIT_DONE_O));
endmodule
bind dram_ctrl dram_ctrl_checker chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .RAS_N_O(RAS_N_O), .CAS_N_O(CAS_N_O), .WE_N_O(WE_N_O),
    .DQ_OE_O(DQ_OE_O), .REQ_READY_O(REQ_READY_O),
    .INIT_DONE_O(INIT_DONE_O));

// ==== test/dram_model.sv ====
// Behavioural memory module behind the controller pins
`timescale 1ns/1ps
module dram_model #(
    parameter int ACC_NS = 20
) (
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [10:0] addr_i,
    input  wire logic [8:0]  dq_i,
    output logic      [8:0]  dq_o
);
    logic [8:0]  mem [logic [21:0]];
    logic [10:0] row = 11'h0;
    logic [8:0]  last = 9'h0;
    initial dq_o = 9'h1ff;
    always @(negedge ras_n_i) begin
        #1;
        if (cas_n_i) row = addr_i;
    end
    always @(negedge cas_n_i) begin
        if (!ras_n_i && !we_n_i) mem[{row, addr_i}] = dq_i;
        if (!ras_n_i && we_n_i) begin
            last = mem.exists({row, addr_i}) ? mem[{row, addr_i}] : 9'h0;
            dq_o <= #(ACC_NS) last;
        end
    end
    // Released output shows a changed pattern
    always @(posedge cas_n_i) dq_o = ~last;
endmodule

// ==== test/dram_ctrl_tb.sv ====
// Self-checking bench for the memory module controller
`timescale 1ns/1ps
module dram_ctrl_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ref_en = 1'b1;
    logic        vld = 1'b0;
    logic        wr = 1'b0;
    logic [21:0] addr = 22'h0;
    logic [8:0]  wdata = 9'h0;
    logic        rdy, rd_vld, done, ras_n, cas_n, we_n, dq_oe;
    logic [8:0]  rd_data, dq_o, dq_m, dq_i;
    logic [10:0] pin_a;
    logic [8:0]  exp_q [$];
    logic [8:0]  mem [logic [21:0]];
    int          num_errors = 0, tests_run = 0, falls = 0, first = 0, cyc = 0;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge ras_n) begin
        falls++;
        if (first == 0) first = cyc;
    end
    dram_ctrl #(.PWRUP_CYC(20), .IDLE_CYC(2000), .RASP_CYC(30)) dut (
        .CLK_I(clk), .SYS_RST_I(rst), .REFRESH_EN_I(ref_en),
        .REQ_VALID_I(vld), .REQ_WRITE_I(wr), .REQ_ADDR_I(addr),
        .REQ_WDATA_I(wdata), .REQ_READY_O(rdy), .RD_VALID_O(rd_vld),
        .RD_DATA_O(rd_data), .INIT_DONE_O(done), .RAS_N_O(ras_n),
        .CAS_N_O(cas_n), .WE_N_O(we_n), .ADDR_O(pin_a), .DQ_O(dq_o),
        .DQ_OE_O(dq_oe), .DQ_I(dq_i));
    dram_model mdl (.ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
        .addr_i(pin_a), .dq_i(dq_o), .dq_o(dq_m));
    assign dq_i = dq_oe ? dq_o : dq_m;
    task automatic check(input string n, input logic [21:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic req(input logic w, input logic [21:0] a);
        logic [8:0] d;
        int n;
        d = 9'($urandom);
        n = 0;
        vld <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 5000);
        @(posedge clk);
        if (n >= 5000) num_errors++;
        if (w) mem[a] = d;
        else exp_q.push_back(mem.exists(a) ? mem[a] : 9'h0);
    endtask
    task automatic wait_done(input logic v);
        int n;
        n = 0;
        while (done !== v && n < 5000) begin
            @(posedge clk);
            n++;
        end
        check("init_done", v, done);
    endtask
    task automatic drain;
        vld <= 1'b0;
        repeat (20) @(posedge clk);
        check("reads_left", 0, exp_q.size());
    endtask
    always @(negedge clk) begin
        if (rd_vld === 1'b1) begin
            if (exp_q.size() == 0) check("rd_extra", 0, 1);
            else check("rd_data", exp_q.pop_front(), rd_data);
        end
    end
    initial begin
        void'($urandom(32'hfd1a));
        repeat (16) @(posedge clk);
        check("rst_pins", 22'h1c, {ras_n, cas_n, we_n, dq_oe, rdy});
        rst <= 1'b0;
        wait_done(1'b1);
        check("init_falls", 8, falls);
        check("init_pause", 1, first > 35);
        $display("test init done");
        for (int i = 0; i < 300; i++) begin
            req(1'($urandom), {9'h0, 2'($urandom), i % 5 == 0 ? 11'h0 :
                i % 5 == 1 ? 11'h7ff : 11'($urandom)});
            if (i % 4 == 3) drain();
        end
        drain();
        $display("test traffic done");
        falls = 0;
        repeat (4000) @(posedge clk);
        check("refresh", 1, falls >= 2);
        $display("test refresh done");
        ref_en <= 1'b0;
        wait_done(1'b0);
        falls = 0;
        wait_done(1'b1);
        check("wake_falls", 8, falls);
        req(1'b0, 22'h0);
        drain();
        $display("test wake done");
        finish_test();
    end
    initial begin
        #500000;
        num_errors++;
        finish_test();
    end
endmodule
